// File: pes_board.sv
// Board model on the port and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module pes_board (
  input wire logic [3:1] out_i, // Port drive levels
  input wire logic [3:1] oe_i, // Port drive enables
  input wire logic [3:1] level_i, // Board levels on port pins
  input wire logic [1:0] irq_lvl_i, // Board levels on interrupt pins
  output logic [3:1] pin_o, // Resolved port pins
  output logic irq_a_o, // Interrupt pin A
  output logic irq_b_o // Interrupt pin B
);
  // No pull-up here, so the board drives whatever the port leaves
  assign pin_o = (oe_i & out_i) | (~oe_i & level_i);
  assign irq_a_o = irq_lvl_i[0];
  assign irq_b_o = irq_lvl_i[1];
endmodule // pes_board
`default_nettype wire

// File: pes_edge_detect.sv
// Synchronises one interrupt pin and detects the selected edge
`timescale 1ns/1ps
`default_nettype none
module pes_edge_detect
  import pes_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic resetn_i, // Asynchronous reset, active low
  input wire logic pin_i, // Raw interrupt pin
  input wire logic [1:0] edge_sel_i, // Falling select, rising select
  output logic req_o // One-cycle request
);

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic req_ff;
  logic rise;
  logic fall;
  logic nxt_req;
  logic [SYNC_STAGES:0] fill_ff;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;

  always_comb begin
    case (pes_edge_t'(edge_sel_i))
      PES_EDGE_RISE: nxt_req = rise;
      PES_EDGE_FALL: nxt_req = fall;
      PES_EDGE_BOTH: nxt_req = rise | fall;
      default: nxt_req = 1'b0;
    endcase
  end

  // Marks once both sync stages and the previous sample hold real pin levels,
  // so a pin that idles high raises no false edge just after reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fill_ff <= '0;
    end else begin
      fill_ff <= {fill_ff[SYNC_STAGES-1:0], 1'b1};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req & fill_ff[SYNC_STAGES];
    end
  end

  assign req_o = req_ff;

endmodule // pes_edge_detect
`default_nettype wire

// File: pes_pkg.sv
// Package with register map, field layout and reset values of the port block
package pes_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] SMALL_PORT_DATA_IDX = 32'hfffff00e;
  localparam logic [31:0] RISING_EDGE_SELECT_IDX = 32'hfffffc32;
  localparam logic [31:0] RISING_EDGE_SELECT_LOW_IDX = 32'hfffffc32;
  localparam logic [31:0] PULLUP_SELECT_IDX = 32'hfffffc12;
  localparam logic [31:0] FALLING_EDGE_SELECT_IDX = 32'hfffffc22;
  localparam logic [31:0] SMALL_PORT_DIRECTION_IDX = 32'hfffff02e;
  localparam logic [31:0] IRQ_STATUS_IDX = 32'hfffffc40;
  localparam logic [31:0] IRQ_ENABLE_IDX = 32'hfffffc42;

  // Reset values
  localparam logic [15:0] PULLUP_SELECT_RST = 16'h0000;
  localparam logic [15:0] FALLING_EDGE_SELECT_RST = 16'h0000;
  localparam logic [15:0] RISING_EDGE_SELECT_RST = 16'h0000;
  localparam logic [7:0] SMALL_PORT_DIRECTION_RST = 8'hff;
  localparam logic [1:0] IRQ_STATUS_RST = 2'h0;
  localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;

  // Implemented bits of the edge selectors and of the small port
  localparam int EDGE_A_BIT = 2;
  localparam int EDGE_B_BIT = 3;
  localparam logic [15:0] EDGE_SELECT_MASK = 16'h000c;
  localparam logic [7:0] SMALL_PORT_MASK = 8'h0e;
  localparam int SMALL_PORT_LSB = 1;
  localparam int SMALL_PORT_MSB = 3;

  // Valid edge codes, falling select bit then rising select bit
  typedef enum logic [1:0] {
    PES_EDGE_NONE = 2'h0,
    PES_EDGE_RISE = 2'h1,
    PES_EDGE_FALL = 2'h2,
    PES_EDGE_BOTH = 2'h3
  } pes_edge_t;

  // Depth of the pin synchroniser
  localparam int SYNC_STAGES = 2;

endpackage

// File: pes_port.sv
// Pull-up select, edge select and three-bit port with APB register access
//
// Functional notes
// - Pull-up select is sixteen bits wide
// - Pull-up halves writable separately by byte
// - Falling select enables falling-edge detection, byte halves
// - Rising select enables rising edges, resets zero
// - Only rising bits two and three exist
// - Select pair decodes none, rise, fall, both
// - Port data bits one to three drive outputs
// - Input-mode read returns the pin level
// - Input-mode write only updates the latch
// - Output-mode read returns latch, write drives pin
// - Output latch is not initialised by reset
// - Direction resets to ones, zero means output
// - Port pins have no pull-up nor alternate
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pes_port
  import pes_pkg::*;
(
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic resetn_i, // Asynchronous reset, active low
  input wire logic [31:0] paddr_i, // APB address
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction, high for write
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [3:0] pstrb_i, // APB write byte strobes
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error for unmapped address
  output logic [15:0] pullup_en_o, // Pull-up enable per pin
  input wire logic ext_irq_a_i, // External interrupt pin A
  input wire logic ext_irq_b_i, // External interrupt pin B
  output logic [1:0] ext_irq_req_o, // Edge requests, B in bit 1
  output logic irq_o, // Level interrupt
  input wire logic [SMALL_PORT_MSB:SMALL_PORT_LSB] small_port_pin_i, // Pin levels
  output logic [SMALL_PORT_MSB:SMALL_PORT_LSB] small_port_out_o, // Pin drive levels
  output logic [SMALL_PORT_MSB:SMALL_PORT_LSB] small_port_oe_o // Pin drive enables
);

  // Register state
  logic [15:0] pullup_select_ff;
  logic [15:0] falling_edge_select_ff;
  logic [15:0] rising_edge_select_ff;
  logic [7:0] small_port_data_ff;
  logic [7:0] small_port_direction_ff;
  logic [1:0] irq_status_ff;
  logic [1:0] irq_enable_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [SMALL_PORT_MSB:SMALL_PORT_LSB] port_oe_ff;
  logic [SMALL_PORT_MSB:SMALL_PORT_LSB] port_out_ff;
  logic irq_ff;

  logic [15:0] nxt_pullup_select;
  logic [15:0] nxt_falling_edge_select;
  logic [15:0] nxt_rising_edge_select;
  logic [7:0] nxt_small_port_data;
  logic [7:0] nxt_small_port_direction;
  logic [1:0] nxt_irq_status;
  logic [1:0] nxt_irq_enable;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  // Bus decode
  logic [29:0] word_addr;
  logic setup_phase;
  logic wr_access;
  logic sel_pullup;
  logic sel_falling;
  logic sel_rising;
  logic sel_data;
  logic sel_direction;
  logic sel_status;
  logic sel_enable;
  logic mapped;

  // Port view and edge requests
  logic [7:0] pin_view;
  logic [7:0] data_read;
  logic [1:0] edge_req;
  logic [1:0] edge_sel_a;
  logic [1:0] edge_sel_b;

  assign word_addr = paddr_i[31:2];
  assign setup_phase = psel_i & ~penable_i;
  assign wr_access = psel_i & penable_i & pwrite_i;

  always_comb begin
    sel_pullup = 1'b0;
    sel_falling = 1'b0;
    sel_rising = 1'b0;
    sel_data = 1'b0;
    sel_direction = 1'b0;
    sel_status = 1'b0;
    sel_enable = 1'b0;
    if (word_addr == PULLUP_SELECT_IDX[29:0]) begin
      sel_pullup = 1'b1;
    end else if (word_addr == FALLING_EDGE_SELECT_IDX[29:0]) begin
      sel_falling = 1'b1;
    end else if (word_addr == RISING_EDGE_SELECT_IDX[29:0]) begin
      sel_rising = 1'b1;
    end else if (word_addr == SMALL_PORT_DATA_IDX[29:0]) begin
      sel_data = 1'b1;
    end else if (word_addr == SMALL_PORT_DIRECTION_IDX[29:0]) begin
      sel_direction = 1'b1;
    end else if (word_addr == IRQ_STATUS_IDX[29:0]) begin
      sel_status = 1'b1;
    end else if (word_addr == IRQ_ENABLE_IDX[29:0]) begin
      sel_enable = 1'b1;
    end
  end

  assign mapped = sel_pullup | sel_falling | sel_rising | sel_data | sel_direction |
                  sel_status | sel_enable;

  // Pull-up select, whole word or either byte half
  always_comb begin
    nxt_pullup_select = pullup_select_ff;
    if (wr_access && sel_pullup) begin
      if (pstrb_i[0]) begin
        nxt_pullup_select[7:0] = pwdata_i[7:0];
      end
      if (pstrb_i[1]) begin
        nxt_pullup_select[15:8] = pwdata_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pullup_select_ff <= PULLUP_SELECT_RST;
    end else begin
      pullup_select_ff <= nxt_pullup_select;
    end
  end

  // Falling select; only the two interrupt bits hold state
  always_comb begin
    nxt_falling_edge_select = falling_edge_select_ff;
    if (wr_access && sel_falling) begin
      if (pstrb_i[0]) begin
        nxt_falling_edge_select[7:0] = pwdata_i[7:0] & EDGE_SELECT_MASK[7:0];
      end
      if (pstrb_i[1]) begin
        nxt_falling_edge_select[15:8] = pwdata_i[15:8] & EDGE_SELECT_MASK[15:8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      falling_edge_select_ff <= FALLING_EDGE_SELECT_RST;
    end else begin
      falling_edge_select_ff <= nxt_falling_edge_select;
    end
  end

  // Rising select; other bits stay zero
  always_comb begin
    nxt_rising_edge_select = rising_edge_select_ff;
    if (wr_access && sel_rising) begin
      if (pstrb_i[0]) begin
        nxt_rising_edge_select[7:0] = pwdata_i[7:0] & EDGE_SELECT_MASK[7:0];
      end
      if (pstrb_i[1]) begin
        nxt_rising_edge_select[15:8] = pwdata_i[15:8] & EDGE_SELECT_MASK[15:8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rising_edge_select_ff <= RISING_EDGE_SELECT_RST;
    end else begin
      rising_edge_select_ff <= nxt_rising_edge_select;
    end
  end

  // Output latch; written whatever the direction
  always_comb begin
    nxt_small_port_data = small_port_data_ff;
    if (wr_access && sel_data && pstrb_i[0]) begin
      nxt_small_port_data = pwdata_i[7:0] & SMALL_PORT_MASK;
    end
  end

  // No reset: latch content is undefined until first written
  always_ff @(posedge clk_i) begin
    small_port_data_ff <= nxt_small_port_data;
  end

  // Direction: one is input, zero is output
  always_comb begin
    nxt_small_port_direction = small_port_direction_ff;
    if (wr_access && sel_direction && pstrb_i[0]) begin
      nxt_small_port_direction = pwdata_i[7:0] | ~SMALL_PORT_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      small_port_direction_ff <= SMALL_PORT_DIRECTION_RST;
    end else begin
      small_port_direction_ff <= nxt_small_port_direction;
    end
  end

  // Edge detectors for the two interrupt pins
  assign edge_sel_a = {falling_edge_select_ff[EDGE_A_BIT], rising_edge_select_ff[EDGE_A_BIT]};
  assign edge_sel_b = {falling_edge_select_ff[EDGE_B_BIT], rising_edge_select_ff[EDGE_B_BIT]};

  pes_edge_detect u_edge_a (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(ext_irq_a_i),
    .edge_sel_i(edge_sel_a),
    .req_o(edge_req[0])
  );

  pes_edge_detect u_edge_b (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(ext_irq_b_i),
    .edge_sel_i(edge_sel_b),
    .req_o(edge_req[1])
  );

  // Sticky status, write one to clear; a new edge wins over the clear
  always_comb begin
    nxt_irq_status = irq_status_ff;
    if (wr_access && sel_status && pstrb_i[0]) begin
      nxt_irq_status = irq_status_ff & ~pwdata_i[1:0];
    end
    nxt_irq_status = nxt_irq_status | edge_req;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_ff <= IRQ_STATUS_RST;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  always_comb begin
    nxt_irq_enable = irq_enable_ff;
    if (wr_access && sel_enable && pstrb_i[0]) begin
      nxt_irq_enable = pwdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_enable_ff <= IRQ_ENABLE_RST;
    end else begin
      irq_enable_ff <= nxt_irq_enable;
    end
  end

  // Data read: pin level for inputs, latch for outputs
  assign pin_view = {4'h0, small_port_pin_i, 1'b0};
  assign data_read = ((pin_view & small_port_direction_ff) |
                      (small_port_data_ff & ~small_port_direction_ff)) & SMALL_PORT_MASK;

  // Read data captured in the setup phase, presented in the access phase
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (setup_phase) begin
      nxt_prdata = 32'h0000_0000;
      if (sel_pullup) begin
        nxt_prdata = {16'h0000, pullup_select_ff};
      end else if (sel_falling) begin
        nxt_prdata = {16'h0000, falling_edge_select_ff};
      end else if (sel_rising) begin
        nxt_prdata = {16'h0000, rising_edge_select_ff};
      end else if (sel_data) begin
        nxt_prdata = {24'h00_0000, data_read};
      end else if (sel_direction) begin
        nxt_prdata = {24'h00_0000, small_port_direction_ff};
      end else if (sel_status) begin
        nxt_prdata = {30'h0000_0000, irq_status_ff};
      end else if (sel_enable) begin
        nxt_prdata = {30'h0000_0000, irq_enable_ff};
      end
      nxt_pslverr = ~mapped;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Outputs
  assign prdata_o = prdata_ff;
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_ff & psel_i & penable_i;
  assign pullup_en_o = pullup_select_ff;
  assign ext_irq_req_o = edge_req;
  assign irq_o = irq_ff;
  assign small_port_oe_o = port_oe_ff;
  assign small_port_out_o = port_out_ff;

  // Level interrupt from a flop fed by next values, so it does not lag the status
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_ff <= |(IRQ_STATUS_RST & IRQ_ENABLE_RST);
    end else begin
      irq_ff <= |(nxt_irq_status & nxt_irq_enable);
    end
  end

  // Pins driven only by latch and direction, loaded with the write so the
  // level appears at once; gated so reset never drives the unknown latch
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_oe_ff <= ~SMALL_PORT_DIRECTION_RST[SMALL_PORT_MSB:SMALL_PORT_LSB];
      port_out_ff <= 3'h0;
    end else begin
      port_oe_ff <= ~nxt_small_port_direction[SMALL_PORT_MSB:SMALL_PORT_LSB];
      port_out_ff <= nxt_small_port_data[SMALL_PORT_MSB:SMALL_PORT_LSB] &
                     ~nxt_small_port_direction[SMALL_PORT_MSB:SMALL_PORT_LSB];
    end
  end

endmodule // pes_port
`default_nettype wire

// File: pes_port_asserts.sv
// Assertion checker for the port block
`timescale 1ns/1ps
`default_nettype none
module pes_port_asserts
  import pes_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic pslverr_o, // APB error
  input wire logic [15:0] pullup_en_o, // Pull-up enables
  input wire logic ext_irq_a_i, // Interrupt pin A
  input wire logic [1:0] ext_irq_req_o, // Edge requests
  input wire logic irq_o, // Level interrupt
  input wire logic [SMALL_PORT_MSB:SMALL_PORT_LSB] small_port_out_o, // Drive levels
  input wire logic [SMALL_PORT_MSB:SMALL_PORT_LSB] small_port_oe_o // Drive enables
);
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_PULLUP_HOLD: assert property (!wr && !$past(wr) |=> $stable(pullup_en_o))
    else $error("pull-up enables moved without a write");
  AST_OE_HOLD: assert property (!wr && !$past(wr) |=> $stable(small_port_oe_o))
    else $error("port enables moved without a write");
  AST_OUT_HOLD: assert property (!wr && !$past(wr) |=> $stable(small_port_out_o))
    else $error("port levels moved without a write");
  AST_OUT_GATED: assert property ((small_port_out_o & ~small_port_oe_o) == 3'h0)
    else $error("undriven port bit shows a level");
  AST_ERR_PHASE: assert property (pslverr_o |-> psel_i && penable_i &&
    $past(psel_i) && !$past(penable_i))
    else $error("error flag outside the first access cycle");
  AST_REQ_CAUSE: assert property (ext_irq_req_o[0] |->
    ($past(ext_irq_a_i, 2) != $past(ext_irq_a_i, 3)) ||
    ($past(ext_irq_a_i, 3) != $past(ext_irq_a_i, 4)) ||
    ($past(ext_irq_a_i, 4) != $past(ext_irq_a_i, 5)) ||
    ($past(ext_irq_a_i, 5) != $past(ext_irq_a_i, 6)))
    else $error("request without a pin edge");
  AST_REQ_QUIET: assert property ($stable(ext_irq_a_i) [*6] |=> !ext_irq_req_o[0])
    else $error("request on a quiet pin");
  AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(|ext_irq_req_o) || $past(wr))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wr))
    else $error("interrupt fell without a write");
endmodule // pes_port_asserts
`default_nettype wire

// File: testbench.sv
// Self-checking testbench of the port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pes_pkg::*;
  logic clk_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, irq_a, irq_b, irq;
  logic [15:0] pu_en;
  logic [1:0] req, irq_lvl = 0;
  logic [3:1] pin, out, oe, pin_lvl = 3'h5;
  int bad_count = 0, checks = 0, cyc = 0;
  int n_req[2];
  always #10 clk_i = ~clk_i;
  pes_port i_pes_port (.clk_i(clk_i), .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pullup_en_o(pu_en),
    .ext_irq_a_i(irq_a), .ext_irq_b_i(irq_b), .ext_irq_req_o(req), .irq_o(irq),
    .small_port_pin_i(pin), .small_port_out_o(out), .small_port_oe_o(oe));
  pes_board i_pes_board (.out_i(out), .oe_i(oe), .level_i(pin_lvl), .irq_lvl_i(irq_lvl),
    .pin_o(pin), .irq_a_o(irq_a), .irq_b_o(irq_b));
  always @(posedge clk_i) begin
    if (req[0] === 1'b1) n_req[0]++;
    if (req[1] === 1'b1) n_req[1]++;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] ad(input logic [31:0] idx);
    return idx << 2;
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    repeat (2) @(negedge clk_i);
    chk("oe reset", oe, 3'h0);
    chk("pull-up reset", pu_en, 16'h0);
    apb(1'b0, ad(SMALL_PORT_DIRECTION_IDX), 0, 4'h0, r, e);
    chk("direction reset", r, 32'hff);
    apb(1'b0, ad(RISING_EDGE_SELECT_IDX), 0, 4'h0, r, e);
    chk("rising reset", r, 32'h0);
    apb(1'b0, ad(SMALL_PORT_DATA_IDX), 0, 4'h0, r, e);
    chk("data pin level", r, 32'ha);
    apb(1'b1, ad(PULLUP_SELECT_IDX), 32'hffff, 4'h3, r, e);
    apb(1'b1, ad(PULLUP_SELECT_IDX), 32'h0, 4'h1, r, e);
    repeat (2) @(negedge clk_i);
    chk("pull-up out", pu_en, 16'hff00);
    apb(1'b1, 32'h0, 32'h0, 4'h3, r, e);
    chk("unmapped write error", e, 1'b1);
    apb(1'b0, ad(PULLUP_SELECT_IDX), 0, 4'h0, r, e);
    chk("pull-up read", r, 32'hff00);
    apb(1'b1, ad(RISING_EDGE_SELECT_IDX), 32'hffff, 4'h3, r, e);
    apb(1'b0, ad(RISING_EDGE_SELECT_IDX), 0, 4'h0, r, e);
    chk("rising bits", r, 32'hc);
    apb(1'b1, ad(FALLING_EDGE_SELECT_IDX), 32'hffff, 4'h3, r, e);
    apb(1'b0, ad(FALLING_EDGE_SELECT_IDX), 0, 4'h0, r, e);
    chk("falling bits", r, 32'hc);
    $display("register test done");
  endtask
  task automatic t_port;
    logic [31:0] r;
    logic e;
    apb(1'b1, ad(SMALL_PORT_DATA_IDX), 32'hff, 4'h1, r, e);
    repeat (2) @(negedge clk_i);
    chk("input mode drive", {oe, out}, 6'h0);
    apb(1'b1, ad(SMALL_PORT_DIRECTION_IDX), 32'h0, 4'h1, r, e);
    repeat (2) @(negedge clk_i);
    chk("latch kept", {oe, out}, 6'h3f);
    apb(1'b1, ad(SMALL_PORT_DATA_IDX), 32'ha, 4'h1, r, e);
    repeat (2) @(negedge clk_i);
    chk("output level", out, 3'h5);
    apb(1'b0, ad(SMALL_PORT_DIRECTION_IDX), 0, 4'h0, r, e);
    chk("direction read", r, 32'hf1);
    pin_lvl <= 3'h2;
    apb(1'b1, ad(SMALL_PORT_DIRECTION_IDX), 32'hf5, 4'h1, r, e);
    apb(1'b0, ad(SMALL_PORT_DATA_IDX), 0, 4'h0, r, e);
    chk("mixed read", r, 32'he);
    apb(1'b1, ad(SMALL_PORT_DIRECTION_IDX), 32'hff, 4'h1, r, e);
    $display("port test done");
  endtask
  task automatic t_edge;
    logic [31:0] r;
    logic e;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, ad(FALLING_EDGE_SELECT_IDX), c[1] ? 32'h4 << p : 32'h0, 4'h3, r, e);
        apb(1'b1, ad(RISING_EDGE_SELECT_IDX), c[0] ? 32'h4 << p : 32'h0, 4'h3, r, e);
        n_req = '{0, 0};
        irq_lvl[p] <= 1'b1;
        repeat (10) @(posedge clk_i);
        irq_lvl[p] <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("edge requests", n_req[p], c[0] + c[1]);
        chk("other pin quiet", n_req[1 - p], 0);
      end
      // Clear the pair before the pin returns to port use
      apb(1'b1, ad(FALLING_EDGE_SELECT_IDX), 32'h0, 4'h3, r, e);
      apb(1'b1, ad(RISING_EDGE_SELECT_IDX), 32'h0, 4'h3, r, e);
    end
    $display("edge test done");
  endtask
  task automatic t_irq;
    logic [31:0] r;
    logic e;
    apb(1'b1, ad(IRQ_STATUS_IDX), 32'h3, 4'h1, r, e);
    apb(1'b1, ad(RISING_EDGE_SELECT_IDX), 32'h4, 4'h3, r, e);
    irq_lvl[0] <= 1'b1;
    repeat (10) @(negedge clk_i);
    chk("masked irq", irq, 1'b0);
    apb(1'b0, ad(IRQ_STATUS_IDX), 0, 4'h0, r, e);
    chk("status set", r, 32'h1);
    apb(1'b1, ad(IRQ_ENABLE_IDX), 32'h1, 4'h1, r, e);
    repeat (2) @(negedge clk_i);
    chk("enabled irq", irq, 1'b1);
    apb(1'b1, ad(IRQ_STATUS_IDX), 32'h1, 4'h1, r, e);
    repeat (2) @(negedge clk_i);
    chk("cleared irq", irq, 1'b0);
    @(posedge clk_i);
    irq_lvl[0] <= 1'b0;
    // Unused inputs keep their pair at none
    apb(1'b1, ad(RISING_EDGE_SELECT_IDX), 32'h0, 4'h3, r, e);
    $display("interrupt test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_port();
    t_edge();
    t_irq();
    give_verdict();
  end
endmodule // testbench
bind pes_port pes_port_asserts i_pes_port_asserts (.clk_i, .resetn_i, .psel_i, .penable_i,
  .pwrite_i, .pslverr_o, .pullup_en_o, .ext_irq_a_i, .ext_irq_req_o, .irq_o,
  .small_port_out_o, .small_port_oe_o);
`default_nettype wire
